// file: hdl/target_azimuth_histogram.sv
// target azimuth histogram: occurrence accumulator, smoothed buffer and symbology window
// What this block does
// R1: logic runs only while the processing enable discrete is asserted.
// R2: one angle conversion per detect pulse arriving while none is busy; angle ignored otherwise.
// R3: each conversion yields a 6-bit unsigned azimuth bin number.
// R4: accumulator holds 64 six-bit counts and circulates output back to input.
// R5: accumulator cleared to zero at the start of every sample period.
// R6: accumulator shifts one entry per 1.639 MHz circulation tick.
// R7: 6-bit bin counter advances per shift, naming the bin at the output.
// R8: latched bin matches counter: write back entry plus one, else unchanged.
// R9: one full circulation is shorter than one angle conversion.
// R10: period end halts, aligns with display buffer, then transfers all entries.
// R11: new buffer entry is accumulator entry plus old entry, halved.
// R12: sample period length set by the operator sample-period control.
// R13: display buffer read in lockstep with display memory read addresses.
// R14: read addresses decoded to symbology window; video shown, radar inhibited inside.
// R15: all counters and timing derived from the single master clock.
// R16: a full count saturates on a further match instead of wrapping.
// R17: while disabled, symbology inactive and no stored contents change.
`timescale 1ns/1ps
module target_azimuth_histogram
  import target_azimuth_histogram_pkg::*;
#(
  parameter int CONV_CYCLES        = `TAH_CONV_CYCLES,
  parameter int SAMPLE_UNIT_CYCLES = `TAH_SAMPLE_UNIT_CYCLES,
  parameter int CIRC_DIV           = `TAH_CIRC_DIV
) (
  input  wire logic                        mclk,                     // master clock
  input  wire logic                        reset,                    // async reset, active high
  input  wire logic                        processingEnableDiscrete, // operator enable pin
  input  wire logic                        targetDetectPulse,        // one pulse per target
  input  wire logic [`TAH_ANGLE_BITS-1:0]  targetAngleInput,         // signed angle sample
  input  wire logic [`TAH_SAMPLE_BITS-1:0] samplePeriodControl,      // sample period setting
  input  wire rasterAddr_t                 readAddr,                 // display memory read address
  output symbology_t                       symbology                 // symbol level and window
);

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  generate
    // a conversion shorter than one circulation could replace a held bin before its entry comes round
    if (CIRC_DIV < 1 || CONV_CYCLES <= CIRC_DIV * `TAH_BIN_COUNT) begin : g_badConv // R9
      $error("conversion must outlast one full accumulator circulation");
    end
    // the divider counter is 16 bits wide and the period needs a nonzero unit
    if (SAMPLE_UNIT_CYCLES < 1 || CIRC_DIV > 65535) begin : g_badTiming
      $error("timing parameters out of range");
    end
    // one bin counter value per accumulator entry
    if (`TAH_BIN_COUNT != (1 << `TAH_BIN_BITS)) begin : g_badBins
      $error("bin count must match the bin number width");
    end
  endgenerate

  localparam logic [31:0] CONV_LAST = 32'(CONV_CYCLES - 1);
  localparam logic [15:0] CIRC_LAST = 16'(CIRC_DIV - 1);

  // ****************************************************************
  // helpers
  // ****************************************************************
  // clamp the signed angle to the bin range, then offset so the most negative angle is bin zero
  function automatic logic [`TAH_BIN_BITS-1:0] angleToBin(input logic [`TAH_ANGLE_BITS-1:0] a);
    logic signed [`TAH_ANGLE_BITS-1:0] s;
    logic signed [`TAH_ANGLE_BITS-1:0] c;
    s = $signed(a);
    if (s < -7'sd32) begin
      c = -7'sd32;
    end else if (s > 7'sd31) begin
      c = 7'sd31;
    end else begin
      c = s;
    end
    angleToBin = 6'(c + 7'sd32);
  endfunction : angleToBin

  function automatic logic [`TAH_BIN_BITS-1:0] satInc(input logic [`TAH_BIN_BITS-1:0] v);
    satInc = (v == `TAH_COUNT_MAX) ? v : 6'(v + 6'h01);
  endfunction : satInc

  // one circulation step: entries move toward the output, e enters at the input end
  function automatic binArray_t shiftIn(input binArray_t a, input logic [`TAH_BIN_BITS-1:0] e);
    shiftIn = {a[`TAH_BIN_COUNT-2:0], e};
  endfunction : shiftIn

  // symbology band decode as an offset compare, so a zero start needs no always-true term
  function automatic logic windowHit(input logic [`TAH_ADDR_BITS-1:0] v);
    windowHit = 9'(v - `TAH_WIN_V_START) <= 9'(`TAH_WIN_V_END - `TAH_WIN_V_START);
  endfunction : windowHit

  // ****************************************************************
  // state
  // ****************************************************************
  state_t q;
  state_t d;
  logic [35:0]                periodLen;
  logic                       tick;
  logic                       detEdge;
  logic [`TAH_BIN_BITS-1:0]   outEntry;
  logic [`TAH_BIN_BITS:0]     smoothSum;
  logic [`TAH_BIN_BITS-1:0]   readBin;
  logic                       inWindow;

  // outputs come straight from the state register
  assign symbology = q.sym;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    d         = q;
    periodLen = 36'(SAMPLE_UNIT_CYCLES) * 36'({28'h0, q.sampSync} + 36'h1); // R12
    tick      = (q.circCnt == CIRC_LAST);
    detEdge   = q.detSync & ~q.detPrev;
    outEntry  = q.accum[`TAH_BIN_COUNT-1];
    smoothSum = {1'b0, outEntry} + {1'b0, q.buffer[q.binCnt]};
    readBin   = readAddr.hAddr[`TAH_HBIN_LSB +: `TAH_BIN_BITS];
    inWindow  = windowHit(readAddr.vAddr);

    // pin synchronisers
    d.enMeta   = processingEnableDiscrete;
    d.enSync   = q.enMeta;
    d.detMeta  = targetDetectPulse;
    d.detSync  = q.detMeta;
    d.detPrev  = q.detSync;
    d.angMeta  = targetAngleInput;
    d.angSync  = q.angMeta;
    d.sampMeta = samplePeriodControl;
    d.sampSync = q.sampMeta;

    // disabled: the machine holds and the output clears; only the pin synchronisers keep sampling
    if (!q.enSync) begin
      d.sym.level  = 6'h00;                                          // R17
      d.sym.window = 1'b0;                                           // R1
    end else begin
      // readout follows the raster address every cycle
      d.sym.window = inWindow;                                       // R14
      d.sym.level  = inWindow ? q.buffer[readBin] : 6'h00;           // R13

      // angle conversion, started once per detect pulse edge
      if (detEdge && !q.convBusy) begin
        d.convBusy  = 1'b1;                                          // R2
        d.convCnt   = 32'h0;
        d.convAngle = q.angSync;
      end else if (q.convBusy) begin
        d.convCnt = q.convCnt + 32'h1;
      end

      // circulation clock divider from the master clock
      d.circCnt = tick ? 16'h0 : 16'(q.circCnt + 16'h1);             // R15

      case (q.phase)
        ST_CLEAR: begin
          // zeros enter at the input while the old counts leave at the output
          d.accum   = shiftIn(q.accum, 6'h00);                       // R5
          d.binCnt  = 6'(q.binCnt + 6'h01);
          d.stepCnt = 7'(q.stepCnt + 7'h01);
          if (q.stepCnt == 7'(`TAH_BIN_COUNT - 1)) begin
            d.phase     = ST_ACCUM;
            d.stepCnt   = 7'h00;
            d.periodCnt = 36'h0;
            d.circCnt   = 16'h0;
          end
        end
        ST_ACCUM: begin
          d.periodCnt = q.periodCnt + 36'h1;
          if (tick) begin
            d.binCnt = 6'(q.binCnt + 6'h01);                         // R7
            // a held bin is counted only here; it waits through clear, align and transfer
            if (q.holdValid && q.holdBin == q.binCnt) begin
              d.accum     = shiftIn(q.accum, satInc(outEntry));       // R8 R16
              d.holdValid = 1'b0;
            end else begin
              d.accum = shiftIn(q.accum, outEntry);                  // R4 R6
            end
          end
          if (q.periodCnt >= periodLen - 36'h1) begin
            d.phase = ST_ALIGN;                                      // R10
          end
        end
        ST_ALIGN: begin
          // spin the halted accumulator until bin zero sits at its output
          if (q.binCnt != 6'h00) begin
            d.accum  = shiftIn(q.accum, outEntry);
            d.binCnt = 6'(q.binCnt + 6'h01);
          end else begin
            d.phase   = ST_TRANSFER;                                 // R10
            d.stepCnt = 7'h00;
          end
        end
        ST_TRANSFER: begin
          // halving truncates; the 7-bit sum keeps the carry of two full counts
          d.buffer[q.binCnt] = smoothSum[`TAH_BIN_BITS:1];           // R11
          d.accum   = shiftIn(q.accum, outEntry);
          d.binCnt  = 6'(q.binCnt + 6'h01);
          d.stepCnt = 7'(q.stepCnt + 7'h01);
          if (q.stepCnt == 7'(`TAH_BIN_COUNT - 1)) begin
            d.phase   = ST_CLEAR;
            d.stepCnt = 7'h00;
          end
        end
        default: d.phase = ST_CLEAR;
      endcase

      // conversion done: latch the bin; a new result wins over a match clear
      if (q.convBusy && q.convCnt == CONV_LAST) begin
        d.convBusy  = 1'b0;
        d.holdBin   = angleToBin(q.convAngle);                       // R3 R9
        d.holdValid = 1'b1;
      end
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule : target_azimuth_histogram

// file: hdl/target_azimuth_histogram_pkg.sv
// types for the target azimuth histogram
`include "target_azimuth_histogram_regs.svh"
package target_azimuth_histogram_pkg;
  typedef enum logic [1:0] {
    ST_CLEAR    = 2'b00,
    ST_ACCUM    = 2'b01,
    ST_ALIGN    = 2'b10,
    ST_TRANSFER = 2'b11
  } phase_t;

  typedef logic [`TAH_BIN_COUNT-1:0][`TAH_BIN_BITS-1:0] binArray_t;

  typedef struct packed {
    logic [`TAH_ADDR_BITS-1:0] hAddr;
    logic [`TAH_ADDR_BITS-1:0] vAddr;
  } rasterAddr_t;

  typedef struct packed {
    logic [`TAH_BIN_BITS-1:0] level;
    logic                     window;
  } symbology_t;

  typedef struct packed {
    phase_t                    phase;
    logic                      enMeta;
    logic                      enSync;
    logic                      detMeta;
    logic                      detSync;
    logic                      detPrev;
    logic [`TAH_ANGLE_BITS-1:0] angMeta;
    logic [`TAH_ANGLE_BITS-1:0] angSync;
    logic [`TAH_SAMPLE_BITS-1:0] sampMeta;
    logic [`TAH_SAMPLE_BITS-1:0] sampSync;
    logic                      convBusy;
    logic [31:0]               convCnt;
    logic [`TAH_ANGLE_BITS-1:0] convAngle;
    logic [`TAH_BIN_BITS-1:0]  holdBin;
    logic                      holdValid;
    logic [15:0]               circCnt;
    logic [`TAH_BIN_BITS-1:0]  binCnt;
    logic [`TAH_BIN_BITS:0]    stepCnt;
    logic [35:0]               periodCnt;
    binArray_t                 accum;
    binArray_t                 buffer;
    symbology_t                sym;
  } state_t;
endpackage : target_azimuth_histogram_pkg

// file: hdl/target_azimuth_histogram_regs.svh
// constants for the target azimuth histogram: sizes, rates and window placement
`ifndef TARGET_AZIMUTH_HISTOGRAM_REGS_SVH
`define TARGET_AZIMUTH_HISTOGRAM_REGS_SVH
`define TAH_BIN_BITS       6
`define TAH_BIN_COUNT      64
`define TAH_COUNT_MAX      6'h3F
`define TAH_ANGLE_BITS     7
`define TAH_MCLK_HZ        200000000
`define TAH_CIRC_HZ        1639000
`define TAH_CIRC_DIV       (`TAH_MCLK_HZ / `TAH_CIRC_HZ)
`define TAH_CONV_NS        50000
`define TAH_CONV_CYCLES    ((`TAH_CONV_NS * (`TAH_MCLK_HZ / 1000000) + 999) / 1000)
`define TAH_SAMPLE_UNIT_MS 100
`define TAH_SAMPLE_UNIT_CYCLES (`TAH_SAMPLE_UNIT_MS * (`TAH_MCLK_HZ / 1000))
`define TAH_ADDR_BITS      9
`define TAH_HBIN_LSB       3
`define TAH_WIN_V_START    9'h000
`define TAH_WIN_V_END      9'h00F
`define TAH_SAMPLE_BITS    4
`endif

// file: tb/target_azimuth_histogram_checker.sv
// assertions on the target azimuth histogram ports
`timescale 1ns/1ps
`include "target_azimuth_histogram_regs.svh"
module target_azimuth_histogram_checker
  import target_azimuth_histogram_pkg::*;
#(
  parameter int CONV_CYCLES        = 200,
  parameter int SAMPLE_UNIT_CYCLES = 500,
  parameter int CIRC_DIV           = 2
) (
  input wire logic        mclk,                     // master clock
  input wire logic        reset,                    // async reset
  input wire logic        processingEnableDiscrete, // enable pin
  input wire rasterAddr_t readAddr,                 // raster address
  input wire symbology_t  symbology                 // overlay output
);
  // ****
  // properties
  // ****
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  chk_first_idle: assert property ($fell(reset) |-> symbology == '0)
    else $error("output active after reset");
  chk_off_quiet: assert property (!processingEnableDiscrete [*3] |=> symbology == '0)
    else $error("output active while disabled");
  chk_win_decode: assert property (processingEnableDiscrete [*4] |=>
    symbology.window == ($past(readAddr.vAddr) <= `TAH_WIN_V_END)) else $error("window decode wrong");
  chk_out_gate: assert property (!symbology.window |-> symbology.level == '0)
    else $error("level outside window");
  chk_win_needs_en: assert property (symbology.window |-> $past(processingEnableDiscrete, 2) ||
    $past(processingEnableDiscrete, 3)) else $error("window while disabled");
  chk_smooth_cap: assert property (symbology.window && $past(symbology.window) &&
    $past(readAddr) == $past(readAddr, 2) |-> symbology.level <= (7'($past(symbology.level)) + 7'h3F) >> 1)
    else $error("smoothing step too large");
  chk_smooth_floor: assert property (symbology.window && $past(symbology.window) &&
    $past(readAddr) == $past(readAddr, 2) |-> symbology.level >= ($past(symbology.level) >> 1))
    else $error("smoothing step too small");
  chk_wake_time: assert property ($rose(processingEnableDiscrete) ##1
    (processingEnableDiscrete && readAddr.vAddr <= `TAH_WIN_V_END) [*4] |=> symbology.window)
    else $error("window late after enable");
endmodule : target_azimuth_histogram_checker
bind target_azimuth_histogram target_azimuth_histogram_checker #(
  .CONV_CYCLES(CONV_CYCLES), .SAMPLE_UNIT_CYCLES(SAMPLE_UNIT_CYCLES), .CIRC_DIV(CIRC_DIV)
) u_chk (.mclk(mclk), .reset(reset), .processingEnableDiscrete(processingEnableDiscrete),
  .readAddr(readAddr), .symbology(symbology));

// file: tb/target_azimuth_histogram_tb.sv
// self-checking testbench for the target azimuth histogram
`timescale 1ns/1ps
module target_azimuth_histogram_tb import target_azimuth_histogram_pkg::*;;
  logic        mclk, reset, enable, fire, pulse;
  logic [6:0]  angleSet, angle;
  logic [3:0]  period;
  logic [5:0]  lvl, keep;
  rasterAddr_t readAddr;
  symbology_t  symbology;
  int          bad_count = 0;
  int          compares = 0;
  target_azimuth_histogram #(.CONV_CYCLES(200), .SAMPLE_UNIT_CYCLES(500), .CIRC_DIV(2)) u_dut (
    .mclk(mclk), .reset(reset), .processingEnableDiscrete(enable), .targetDetectPulse(pulse),
    .targetAngleInput(angle), .samplePeriodControl(period), .readAddr(readAddr), .symbology(symbology));
  target_detector_model u_src (.mclk(mclk), .fire(fire), .angleSet(angleSet), .pulse(pulse), .angle(angle));
  // ****
  // tasks
  // ****
  task automatic check(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask : check
  task automatic cycles(input int n);
    repeat (n) @(posedge mclk);
  endtask : cycles
  task automatic read_bin(input int h, output logic [5:0] v);
    readAddr <= '{hAddr: 9'(h), vAddr: 9'h000};
    cycles(3);
    v = symbology.level;
  endtask : read_bin
  task automatic shoot(input logic [6:0] a);
    angleSet <= a;
    fire <= 1'b1;
    cycles(1);
    fire <= 1'b0;
  endtask : shoot
  task automatic t_idle;
    read_bin(96, lvl);
    shoot(7'h6C);
    cycles(300);
    check(symbology === '0, "output active while disabled");
  endtask : t_idle
  task automatic t_window;
    enable <= 1'b1;
    cycles(6);
    check(symbology.window === 1'b1, "window missing on row 0");
    readAddr <= '{hAddr: 9'h060, vAddr: 9'h010};
    cycles(3);
    check(symbology === '0, "window shown on row 16");
    readAddr <= '{hAddr: 9'h060, vAddr: 9'h00F};
    cycles(3);
    check(symbology.window === 1'b1, "window missing on row 15");
  endtask : t_window
  task automatic t_accumulate;
    for (int i = 0; i < 72; i++) begin
      shoot(i[0] ? 7'h1F : 7'h60);  // alternate the two end bins
      cycles(229);
    end
    read_bin(5, lvl);
    check(lvl inside {[6'h02:6'h09]}, "bin 0 count off");
    read_bin(509, keep);
    check(keep inside {[6'h02:6'h09]}, "bin 63 count off");
    read_bin(504, lvl);
    check(lvl === keep, "bin read not in step");
    for (int b = 1; b < 63; b += 11) begin
      read_bin(b * 8 + 3, lvl);
      check(lvl === 6'h00, "stray count");
    end
  endtask : t_accumulate
  task automatic t_freeze;
    read_bin(511, keep);
    enable <= 1'b0;
    cycles(3000);
    check(symbology === '0, "output active while disabled");
    enable <= 1'b1;
    cycles(5);
    check(symbology.level === keep, "contents changed while disabled");
  endtask : t_freeze
  task automatic t_decay;
    int last = 0;
    int seen = 0;
    period <= 4'h1;
    read_bin(5, lvl);
    cycles(600);
    lvl = symbology.level;
    for (int n = 0; n < 9000 && lvl !== 6'h00; n++) begin
      cycles(1);
      if (symbology.level !== lvl) begin
        check(symbology.level === (lvl >> 1), "smoothing step wrong");
        if (seen > 0) check((n - last) inside {[1128:1200]}, "sample period length wrong");
        seen++;
        last = n;
        lvl = symbology.level;
      end
    end
    check(seen > 1 && lvl === 6'h00, "buffer did not decay");
  endtask : t_decay
  task automatic stop_test;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    reset = 1'b1;
    enable = 1'b0;
    fire = 1'b0;
    angleSet = 7'h00;
    period = 4'h7;
    readAddr = '0;
    cycles(12);
    reset <= 1'b0;
    cycles(2);
    t_idle();
    t_window();
    t_accumulate();
    t_freeze();
    t_decay();
    stop_test();
  end
  initial begin
    #300000;
    bad_count++;
    stop_test();
  end
endmodule : target_azimuth_histogram_tb

// file: tb/target_detector_model.sv
// behavioural detection source: one fixed-width pulse per target
`timescale 1ns/1ps
module target_detector_model (
  input  wire logic       mclk,            // master clock
  input  wire logic       fire,            // request one detection
  input  wire logic [6:0] angleSet,        // angle of that target
  output logic            pulse = 1'b0,    // detect pulse
  output logic [6:0]      angle = 7'h00    // angle line
);
  int age = 99;
  always @(posedge mclk) begin
    if (fire) begin
      age <= 0;
      angle <= angleSet;
    end else begin
      age <= age + 1;
      if (age > 8) angle <= ~angle;  // stale once the pulse is long gone
    end
    pulse <= fire || (age < 3);
  end
endmodule : target_detector_model
